// ===== hw/dmrop_pkg.sv
package dmrop_pkg;
    localparam int RESULT_WIDTH = 12;
    localparam int LOW_WIDTH = 8;
    localparam int HIGH_WIDTH = 6;
    localparam int WORD_WIDTH = 14;
    localparam int FIFO_DEPTH = 8;
    localparam logic [13:0] WORD_RESET = 14'h0000;
    // bit positions inside the stored 14-bit word
    localparam int OVERRANGE_POS = 13;
    localparam int SIGN_POS = 12;
    localparam int STATUS_BIT_POS = 7;
    // cycles spent with the high byte selected before the request is looked at;
    // covers the pin filter so a peripheral answering the strobe can still stall
    localparam logic [3:0] REQ_SETTLE_COUNT = 4'h8;

    typedef enum logic [4:0] {
        DMROP_IDLE_STATE = 5'h01,
        DMROP_WAIT_HIGH_STATE = 5'h02,
        DMROP_HIGH_STATE = 5'h04,
        DMROP_WAIT_LOW_STATE = 5'h08,
        DMROP_LOW_STATE = 5'h10
    } dmrop_state_type;
endpackage : dmrop_pkg

// ===== hw/dmrop_fifo.sv
`timescale 1ns/1ps
module dmrop_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic doWrite;
    logic doRead;

    assign inReady = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr_reg[AW-1:0]];

    always_ff @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule : dmrop_fifo

// ===== hw/dmrop_port.sv
`timescale 1ns/1ps
// Summary of operation
// - mode input low selects direct output mode under host read control.
// - mode input is pulled down, so an open pin means direct mode.
// - direct mode enables are active-low inputs pulled up when open.
// - low byte holds result bits 1-8; high byte bits 9-12, sign, overrange.
// - chip enable low plus selects drive high, low or whole word; rest released.
// - high selected, low not, in direct mode: bit eight shows status.
// - mode input held high enters handshake mode.
// - handshake sequence starts automatically after a result is latched that leaves the buffer empty.
// - mode rising edge starts a sequence, delayed while latches update.
// - a handshake sequence turns the three enable pins into device outputs.
// - handshake chip enable goes low as a data-valid strobe.
// - handshake byte selects go low to mark the byte on the bus.
// - request high starts transfer; high byte goes first, low byte second.
// - results finishing during a handshake sequence are not latched, discarded.
// - status high through integrate and deintegrate until latched, else low.
module dmrop_port
    import dmrop_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // converter side: finished results pass through the buffer
    input wire logic [dmrop_pkg::RESULT_WIDTH-1:0] resultBits,
    input wire logic signBit,
    input wire logic overrange,
    input wire logic resultValid,
    output logic resultReady,
    input wire logic convertBusy,
    // pins; pull resistors are modelled by the pad, which floats high or low
    input wire logic modeSelect,
    input wire logic transferRequest,
    input wire logic chipEnableNIn,
    output logic chipEnableNOut,
    output logic chipEnableNOe,
    input wire logic lowByteSelectNIn,
    output logic lowByteSelectNOut,
    output logic lowByteSelectNOe,
    input wire logic highByteSelectNIn,
    output logic highByteSelectNOut,
    output logic highByteSelectNOe,
    output logic [dmrop_pkg::WORD_WIDTH-1:0] dataOut,
    output logic [dmrop_pkg::WORD_WIDTH-1:0] dataOe,
    output logic statusOut
);
    import dmrop_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] pins_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_reg <= 5'h1e;
            sync2_reg <= 5'h1e;
            sync3_reg <= 5'h1e;
            pins_reg <= 5'h1e;
        end else begin
            sync1_reg <= {transferRequest, chipEnableNIn, lowByteSelectNIn,
                          highByteSelectNIn, modeSelect};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 5; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pins_reg[i] <= sync3_reg[i];
                end
            end
        end
    end
    logic modeS;
    logic hbS;
    logic lbS;
    logic ceS;
    logic reqS;
    assign modeS = pins_reg[0];
    assign hbS = pins_reg[1];
    assign lbS = pins_reg[2];
    assign ceS = pins_reg[3];
    assign reqS = pins_reg[4];

    logic modeLast_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            modeLast_reg <= 1'b0;
        end else begin
            modeLast_reg <= modeS;
        end
    end
    logic modeRise;
    assign modeRise = modeS && !modeLast_reg;

    // ------------------------------------------------------------
    // result buffer and output latches
    // ------------------------------------------------------------
    logic [WORD_WIDTH-1:0] fifoIn;
    logic [WORD_WIDTH-1:0] fifoOut;
    logic fifoValid;
    logic fifoTake;
    assign fifoIn = {overrange, signBit, resultBits};
    dmrop_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .inData(fifoIn),
        .inValid(resultValid),
        .inReady(resultReady),
        .outData(fifoOut),
        .outValid(fifoValid),
        .outReady(fifoTake)
    );

    dmrop_state_type state_reg;
    logic inSequence;
    assign inSequence = state_reg != DMROP_IDLE_STATE;

    // the buffer drains always; a word popped mid-sequence is dropped, so the
    // converter never stalls on a slow peripheral
    assign fifoTake = fifoValid;
    logic [WORD_WIDTH-1:0] word_reg;
    logic latchPulse_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            word_reg <= WORD_RESET;
            latchPulse_reg <= 1'b0;
        end else begin
            latchPulse_reg <= fifoTake && !inSequence;
            if (fifoTake && !inSequence) begin
                word_reg <= fifoOut;
            end
        end
    end

    // high while converting until the word is latched
    logic status_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            status_reg <= 1'b0;
        end else begin
            status_reg <= convertBusy || fifoValid;
        end
    end
    assign statusOut = status_reg;

    // ------------------------------------------------------------
    // handshake sequencer
    // ------------------------------------------------------------
    logic pendingEdge_reg;
    logic startSeq;
    // a mode edge during a latch update waits until the buffer has drained, for stable data
    assign startSeq = modeS && !inSequence && !fifoValid
                      && (latchPulse_reg || modeRise || pendingEdge_reg);
    always_ff @(posedge clock) begin
        if (rst) begin
            pendingEdge_reg <= 1'b0;
        end else if (startSeq) begin
            pendingEdge_reg <= 1'b0;
        end else if (modeRise) begin
            pendingEdge_reg <= 1'b1;
        end
    end

    // the request reaches the sequencer through the pin filter, so a drop made in
    // answer to the high byte strobe shows up several cycles late; wait that long
    logic [3:0] settle_reg;
    logic settleDone;
    assign settleDone = settle_reg == REQ_SETTLE_COUNT;
    always_ff @(posedge clock) begin
        if (rst) begin
            settle_reg <= 4'h0;
        end else if (state_reg != DMROP_WAIT_LOW_STATE) begin
            settle_reg <= 4'h0;
        end else if (!settleDone) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= DMROP_IDLE_STATE;
        end else begin
            case (state_reg)
                DMROP_IDLE_STATE: begin
                    if (startSeq) begin
                        state_reg <= DMROP_WAIT_HIGH_STATE;
                    end
                end
                DMROP_WAIT_HIGH_STATE: begin
                    if (reqS) begin
                        state_reg <= DMROP_HIGH_STATE;
                    end
                end
                DMROP_HIGH_STATE: begin
                    state_reg <= DMROP_WAIT_LOW_STATE;
                end
                DMROP_WAIT_LOW_STATE: begin
                    if (settleDone && reqS) begin
                        state_reg <= DMROP_LOW_STATE;
                    end
                end
                DMROP_LOW_STATE: begin
                    state_reg <= DMROP_IDLE_STATE;
                end
                default: begin
                    state_reg <= DMROP_IDLE_STATE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers, all registered
    // ------------------------------------------------------------
    logic handshake;
    assign handshake = inSequence;
    logic ceOut_reg;
    logic lbOut_reg;
    logic hbOut_reg;
    logic enOe_reg;
    logic [WORD_WIDTH-1:0] dOut_reg;
    logic [WORD_WIDTH-1:0] dOe_reg;
    logic [WORD_WIDTH-1:0] highMask;
    logic [WORD_WIDTH-1:0] lowMask;
    assign highMask = {{HIGH_WIDTH{1'b1}}, {LOW_WIDTH{1'b0}}};
    assign lowMask = {{HIGH_WIDTH{1'b0}}, {LOW_WIDTH{1'b1}}};

    always_ff @(posedge clock) begin
        if (rst) begin
            ceOut_reg <= 1'b1;
            lbOut_reg <= 1'b1;
            hbOut_reg <= 1'b1;
            enOe_reg <= 1'b1;
            dOut_reg <= WORD_RESET;
            dOe_reg <= '1;
        end else begin
            dOut_reg <= word_reg;
            if (handshake) begin
                enOe_reg <= 1'b0;
                ceOut_reg <= !(state_reg == DMROP_HIGH_STATE
                               || state_reg == DMROP_LOW_STATE);
                hbOut_reg <= !(state_reg == DMROP_HIGH_STATE
                               || state_reg == DMROP_WAIT_LOW_STATE);
                lbOut_reg <= state_reg != DMROP_LOW_STATE;
                if (state_reg == DMROP_HIGH_STATE || state_reg == DMROP_WAIT_LOW_STATE) begin
                    dOe_reg <= ~highMask;
                end else if (state_reg == DMROP_LOW_STATE) begin
                    dOe_reg <= ~lowMask;
                end else begin
                    dOe_reg <= '1;
                end
            end else begin
                // direct mode: enables are inputs, request ignored
                enOe_reg <= 1'b1;
                ceOut_reg <= 1'b1;
                lbOut_reg <= 1'b1;
                hbOut_reg <= 1'b1;
                dOe_reg <= '1;
                if (!ceS && !modeS) begin
                    if (!hbS && !lbS) begin
                        dOe_reg <= '0;
                    end else if (!hbS) begin
                        dOe_reg <= ~highMask;
                        dOe_reg[STATUS_BIT_POS] <= 1'b0;
                        dOut_reg[STATUS_BIT_POS] <= status_reg;
                    end else if (!lbS) begin
                        dOe_reg <= ~lowMask;
                    end
                end
            end
        end
    end

    assign chipEnableNOut = ceOut_reg;
    assign lowByteSelectNOut = lbOut_reg;
    assign highByteSelectNOut = hbOut_reg;
    assign chipEnableNOe = enOe_reg;
    assign lowByteSelectNOe = enOe_reg;
    assign highByteSelectNOe = enOe_reg;
    assign dataOut = dOut_reg;
    assign dataOe = dOe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_highByte;
        state_reg == DMROP_HIGH_STATE;
    endsequence
    sequence s_lowByte;
        state_reg == DMROP_LOW_STATE;
    endsequence

    property p_highFirst;
        @(posedge clock) disable iff (rst)
        s_highByte |=> !hbOut_reg && !ceOut_reg && lbOut_reg;
    endproperty
    a_highFirst: assert property (p_highFirst) else $error("high byte strobe wrong");

    property p_lowSecond;
        @(posedge clock) disable iff (rst)
        s_lowByte |=> !lbOut_reg && !ceOut_reg && hbOut_reg && dOe_reg == ~lowMask;
    endproperty
    a_lowSecond: assert property (p_lowSecond) else $error("low byte strobe wrong");

    property p_release;
        @(posedge clock) disable iff (rst)
        s_lowByte ##1 1'b1 |=> ceOut_reg && lbOut_reg && hbOut_reg;
    endproperty
    a_release: assert property (p_release) else $error("enables not released");

    property p_stall;
        @(posedge clock) disable iff (rst)
        state_reg == DMROP_WAIT_LOW_STATE && !reqS |=> state_reg == DMROP_WAIT_LOW_STATE;
    endproperty
    a_stall: assert property (p_stall) else $error("stall not held");

    property p_waitIdle;
        @(posedge clock) disable iff (rst)
        state_reg == DMROP_WAIT_HIGH_STATE ##1 state_reg == DMROP_WAIT_HIGH_STATE
        |-> ceOut_reg && lbOut_reg && hbOut_reg && dOe_reg == '1;
    endproperty
    a_waitIdle: assert property (p_waitIdle) else $error("drove before request");

    property p_noLatch;
        @(posedge clock) disable iff (rst)
        inSequence |=> word_reg == $past(word_reg);
    endproperty
    a_noLatch: assert property (p_noLatch) else $error("latched during sequence");

    property p_directIdle;
        @(posedge clock) disable iff (rst)
        !inSequence && ceS |=> dOe_reg == '1 && enOe_reg;
    endproperty
    a_directIdle: assert property (p_directIdle) else $error("bus driven unselected");

    property p_statusBit;
        @(posedge clock) disable iff (rst)
        !inSequence && !modeS && !ceS && !hbS && lbS
        |=> !dOe_reg[STATUS_BIT_POS] && dOut_reg[STATUS_BIT_POS] == $past(status_reg);
    endproperty
    a_statusBit: assert property (p_statusBit) else $error("status bit not shown");

    property p_autoStart;
        @(posedge clock) disable iff (rst)
        startSeq |=> state_reg == DMROP_WAIT_HIGH_STATE ##1 !enOe_reg;
    endproperty
    a_autoStart: assert property (p_autoStart) else $error("sequence did not start");
endmodule : dmrop_port

// ===== sim/dmrop_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------
// receiving peripheral on the handshake side
// ----------------------------------------
module dmrop_far_end (
    input wire logic clock,
    input wire logic rst,
    input wire logic modeSelect,
    input wire logic holdOff,
    input wire logic [3:0] stallLen,
    input wire logic chipEnableN,
    input wire logic lowSelN,
    input wire logic highSelN,
    input wire logic [13:0] dataOut,
    input wire logic [13:0] dataOe,
    output logic transferRequest,
    output logic [13:0] gotWord,
    output logic [3:0] byteCount,
    output logic orderBad
);
    logic [3:0] stallCnt;
    logic expectLow;
    logic grab;
    // parked high outside handshake mode, where the device ignores it
    assign transferRequest = !modeSelect || (!holdOff && stallCnt == 4'h0);
    assign grab = modeSelect && !chipEnableN;
    // released data lines read back as ones, so a missing drive is not masked
    always_ff @(posedge clock) begin
        if (rst) begin
            stallCnt <= 4'h0;
            expectLow <= 1'b0;
            orderBad <= 1'b0;
            byteCount <= 4'h0;
            gotWord <= 14'h0000;
        end else if (grab && !highSelN) begin
            gotWord[13:8] <= dataOut[13:8] | dataOe[13:8];
            stallCnt <= stallLen;
            expectLow <= 1'b1;
            byteCount <= byteCount + 4'h1;
        end else if (grab && !lowSelN) begin
            gotWord[7:0] <= dataOut[7:0] | dataOe[7:0];
            orderBad <= orderBad | !expectLow;
            expectLow <= 1'b0;
            byteCount <= byteCount + 4'h1;
        end else if (stallCnt != 4'h0) begin
            stallCnt <= stallCnt - 4'h1;
        end
    end
endmodule : dmrop_far_end

// ===== sim/dmrop_port_tb.sv
`timescale 1ns/1ps
module dmrop_port_tb;
    import dmrop_pkg::*;
    typedef struct packed {
        logic [2:0] pins;
        logic [13:0] oe;
        logic [13:0] data;
    } dmrop_row_type;
    logic clock, rst, signBit, overrange, resultValid, resultReady, convertBusy;
    logic modeSelect, transferRequest, ceDrv, lbDrv, hbDrv, holdOff, orderBad, statusOut;
    logic chipEnableNOut, chipEnableNOe, lowByteSelectNOut, lowByteSelectNOe;
    logic highByteSelectNOut, highByteSelectNOe, ceWire, lbWire, hbWire;
    logic [11:0] resultBits;
    logic [13:0] dataOut, dataOe, gotWord;
    logic [3:0] stallLen, byteCount;
    logic [13:0] pinOe, pinOut;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    dmrop_row_type rows [5];
    // an enable pin nobody drives sits at its pull-up level
    assign ceWire = chipEnableNOe ? ceDrv : chipEnableNOut;
    assign lbWire = lowByteSelectNOe ? lbDrv : lowByteSelectNOut;
    assign hbWire = highByteSelectNOe ? hbDrv : highByteSelectNOut;
    assign pinOe = 14'({chipEnableNOe, lowByteSelectNOe, highByteSelectNOe});
    assign pinOut = 14'({chipEnableNOut, lowByteSelectNOut, highByteSelectNOut});

    dmrop_port i_dut (.clock(clock), .rst(rst), .resultBits(resultBits), .signBit(signBit),
        .overrange(overrange), .resultValid(resultValid), .resultReady(resultReady),
        .convertBusy(convertBusy), .modeSelect(modeSelect), .transferRequest(transferRequest),
        .chipEnableNIn(ceWire), .chipEnableNOut(chipEnableNOut), .chipEnableNOe(chipEnableNOe),
        .lowByteSelectNIn(lbWire), .lowByteSelectNOut(lowByteSelectNOut),
        .lowByteSelectNOe(lowByteSelectNOe), .highByteSelectNIn(hbWire),
        .highByteSelectNOut(highByteSelectNOut), .highByteSelectNOe(highByteSelectNOe),
        .dataOut(dataOut), .dataOe(dataOe), .statusOut(statusOut));
    dmrop_far_end i_far (.clock(clock), .rst(rst), .modeSelect(modeSelect), .holdOff(holdOff),
        .stallLen(stallLen), .chipEnableN(ceWire), .lowSelN(lbWire), .highSelN(hbWire),
        .dataOut(dataOut), .dataOe(dataOe), .transferRequest(transferRequest),
        .gotWord(gotWord), .byteCount(byteCount), .orderBad(orderBad));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // leaves valid high so bursts run back to back
    task automatic push(input logic [13:0] w);
        {overrange, signBit, resultBits} = w;
        resultValid = 1'b1;
        while (!resultReady) cyc(1);
        cyc(1);
    endtask : push

    // pin changes need a few edges to pass the input filter
    task automatic set_pins(input logic [2:0] p);
        {ceDrv, lbDrv, hbDrv} = p;
        cyc(7);
    endtask : set_pins

    task automatic wait_bytes(input logic [3:0] n);
        for (int k = 0; k < 80 && byteCount != n; k++) cyc(1);
    endtask : wait_bytes

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("MISMATCH %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{3'b100, 14'h3fff, 14'h0000};
        rows[1] = '{3'b000, 14'h0000, 14'h2a9c};
        rows[2] = '{3'b010, 14'h007f, 14'h2a00};
        rows[3] = '{3'b001, 14'h3f00, 14'h009c};
        rows[4] = '{3'b011, 14'h3fff, 14'h0000};
        rst = 1'b1;
        resultValid = 1'b0;
        convertBusy = 1'b0;
        modeSelect = 1'b0;
        holdOff = 1'b0;
        stallLen = 4'h0;
        {ceDrv, lbDrv, hbDrv} = 3'b111;
        {overrange, signBit, resultBits} = 14'h0000;
        cyc(4);
        rst = 1'b0;
        check(dataOe, 14'h3fff, "reset data oe");
        check(14'(statusOut), 14'h0, "reset status");
        check(pinOe, 14'h7, "reset pin oe");
        push(14'h2a9c);
        resultValid = 1'b0;
        cyc(4);
        for (int i = 0; i < 5; i++) begin
            set_pins(rows[i].pins);
            check(dataOe, rows[i].oe, "direct oe");
            check(dataOut & ~rows[i].oe, rows[i].data, "direct data");
        end
        convertBusy = 1'b1;
        set_pins(3'b010);
        check(14'(statusOut), 14'h1, "busy status");
        check(dataOut & 14'h3f80, 14'h2a80, "status on bit eight");
        convertBusy = 1'b0;
        cyc(3);
        check(14'(statusOut), 14'h0, "idle status");
        for (int i = 0; i < 9; i++) push(14'h1000 + 14'(i));
        resultValid = 1'b0;
        while (statusOut) cyc(1);
        set_pins(3'b000);
        check(dataOut, 14'h1008, "last of burst");
        // on-demand entry with the request held low
        {ceDrv, lbDrv, hbDrv} = 3'b111;
        holdOff = 1'b1;
        modeSelect = 1'b1;
        cyc(10);
        check(pinOe, 14'h0, "hs oe");
        check(pinOut, 14'h7, "hs idle");
        check(dataOe, 14'h3fff, "hs data released");
        push(14'h0d35);
        resultValid = 1'b0;
        cyc(10);
        holdOff = 1'b0;
        wait_bytes(4'h2);
        check(gotWord, 14'h1008, "on-demand word");
        check(14'(orderBad), 14'h0, "byte order");
        cyc(4);
        check(pinOut, 14'h7, "hs end");
        check(dataOe, 14'h3fff, "hs end data");
        stallLen = 4'hc;
        push(14'h3456);
        resultValid = 1'b0;
        wait_bytes(4'h3);
        cyc(6);
        check(pinOut, 14'h6, "stalled on high byte");
        check(dataOe, 14'h00ff, "high byte held");
        wait_bytes(4'h4);
        check(gotWord, 14'h3456, "automatic word");
        cyc(30);
        check(14'(byteCount), 14'h4, "one sequence per result");
        check(14'(orderBad), 14'h0, "byte order");
        modeSelect = 1'b0;
        set_pins(3'b000);
        check(dataOut, 14'h3456, "back to direct");
        check(pinOe, 14'h7, "pins input");
        // mode edge while a burst is still being latched: only the settled word goes out
        {ceDrv, lbDrv, hbDrv} = 3'b111;
        modeSelect = 1'b1;
        for (int i = 0; i < 9; i++) push(14'h0200 + 14'(i));
        resultValid = 1'b0;
        wait_bytes(4'h6);
        check(gotWord, 14'h0208, "edge during burst");
        check(14'(orderBad), 14'h0, "byte order");
        modeSelect = 1'b0;
        set_pins(3'b000);
        rst = 1'b1;
        cyc(2);
        check(dataOe, 14'h3fff, "second reset");
        rst = 1'b0;
        cyc(2);
        check(dataOe, 14'h3fff, "pins still filtered");
        cyc(6);
        check(dataOe, 14'h0000, "direct after reset");
        check(dataOut, 14'h0000, "word cleared");
        tally_and_finish();
    end
endmodule : dmrop_port_tb
